// ==== pkg/spr_pkg.sv ====
`default_nettype none
package spr_pkg;

  // read opcode and serial framing counts, in serial clocks
  localparam logic [7:0] CMD_READ_PARAM = 8'h5A;
  localparam logic [5:0] CMD_END = 6'h08;
  localparam logic [5:0] ADDR_HI_END = CMD_END + 6'h10;
  localparam logic [5:0] ADDR_END = ADDR_HI_END + 6'h08;
  localparam logic [5:0] HDR_END = ADDR_END + 6'h08;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // table byte addresses
  localparam logic [7:0] A_HDR_LAST = 8'h0F;
  localparam logic [7:0] A_BASIC = 8'h80;
  localparam logic [7:0] A_BASIC_LAST = 8'hA3;

  // byte values
  localparam logic [7:0] V_RSVD = 8'hFF;
  localparam logic [7:0] V_ZERO = 8'h00;
  localparam logic [31:0] V_SIGNATURE = 32'h50444653;
  localparam logic [7:0] V_REV_MAJOR = 8'h01;
  localparam logic [7:0] V_PARAM_HEADER_COUNT = 8'h00;
  localparam logic [7:0] V_PARAM_TABLE_IDENT = 8'h00;
  localparam logic [7:0] V_TABLE_DWORDS = 8'h09;
  localparam logic [23:0] V_PARAM_TABLE_OFFSET = 24'h000080;
  localparam logic [7:0] V_ERASE_CAPS = 8'hE5;
  localparam logic [7:0] V_OP_ERASE_4K = 8'h20;
  localparam logic [7:0] V_READ_CAPS = 8'hF1;
  localparam logic [31:0] V_DENSITY = 32'h07FFFFFF;
  localparam logic [7:0] V_QIO_WAIT = 8'h44;
  localparam logic [7:0] V_OP_QIO = 8'hEB;
  localparam logic [7:0] V_DUMMY8 = 8'h08;
  localparam logic [7:0] V_OP_QOUT = 8'h6B;
  localparam logic [7:0] V_OP_DOUT = 8'h3B;
  localparam logic [7:0] V_DIO_WAIT = 8'h80;
  localparam logic [7:0] V_OP_DIO = 8'hBB;
  localparam logic [7:0] V_WIDE_CAPS = 8'hFE;
  localparam logic [7:0] V_SIZE_4K = 8'h0C;
  localparam logic [7:0] V_SIZE_32K = 8'h0F;
  localparam logic [7:0] V_OP_ERASE_32K = 8'h52;
  localparam logic [7:0] V_SIZE_64K = 8'h10;
  localparam logic [7:0] V_OP_ERASE_64K = 8'hD8;

  // synchronised pin group
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic di;
  } spr_pins_t;

endpackage
`default_nettype wire

// ==== logic/spr_rom.sv ====
`timescale 1ns/1ns
`default_nettype none
module spr_rom (
  input wire logic [7:0] addr_i, // table byte address
  output logic [7:0] data_o // table byte
);

  // fixed contents, no write path exists at all
  always_comb begin
    case (addr_i)
      8'h00: data_o = spr_pkg::V_SIGNATURE[7:0];
      8'h01: data_o = spr_pkg::V_SIGNATURE[15:8];
      8'h02: data_o = spr_pkg::V_SIGNATURE[23:16];
      8'h03: data_o = spr_pkg::V_SIGNATURE[31:24];
      8'h04: data_o = spr_pkg::V_ZERO;
      8'h05: data_o = spr_pkg::V_REV_MAJOR;
      8'h06: data_o = spr_pkg::V_PARAM_HEADER_COUNT;
      8'h08: data_o = spr_pkg::V_PARAM_TABLE_IDENT;
      8'h09: data_o = spr_pkg::V_ZERO;
      8'h0A: data_o = spr_pkg::V_REV_MAJOR;
      8'h0B: data_o = spr_pkg::V_TABLE_DWORDS;
      8'h0C: data_o = spr_pkg::V_PARAM_TABLE_OFFSET[7:0];
      8'h0D: data_o = spr_pkg::V_PARAM_TABLE_OFFSET[15:8];
      8'h0E: data_o = spr_pkg::V_PARAM_TABLE_OFFSET[23:16];
      8'h80: data_o = spr_pkg::V_ERASE_CAPS;
      8'h81: data_o = spr_pkg::V_OP_ERASE_4K;
      8'h82: data_o = spr_pkg::V_READ_CAPS;
      8'h84: data_o = spr_pkg::V_DENSITY[7:0];
      8'h85: data_o = spr_pkg::V_DENSITY[15:8];
      8'h86: data_o = spr_pkg::V_DENSITY[23:16];
      8'h87: data_o = spr_pkg::V_DENSITY[31:24];
      8'h88: data_o = spr_pkg::V_QIO_WAIT;
      8'h89: data_o = spr_pkg::V_OP_QIO;
      8'h8A: data_o = spr_pkg::V_DUMMY8;
      8'h8B: data_o = spr_pkg::V_OP_QOUT;
      8'h8C: data_o = spr_pkg::V_DUMMY8;
      8'h8D: data_o = spr_pkg::V_OP_DOUT;
      8'h8E: data_o = spr_pkg::V_DIO_WAIT;
      8'h8F: data_o = spr_pkg::V_OP_DIO;
      8'h90: data_o = spr_pkg::V_WIDE_CAPS;
      8'h96: data_o = spr_pkg::V_ZERO;
      8'h97: data_o = spr_pkg::V_ZERO;
      8'h9A: data_o = spr_pkg::V_DUMMY8;
      8'h9B: data_o = spr_pkg::V_OP_QIO;
      8'h9C: data_o = spr_pkg::V_SIZE_4K;
      8'h9D: data_o = spr_pkg::V_OP_ERASE_4K;
      8'h9E: data_o = spr_pkg::V_SIZE_32K;
      8'h9F: data_o = spr_pkg::V_OP_ERASE_32K;
      8'hA0: data_o = spr_pkg::V_SIZE_64K;
      8'hA1: data_o = spr_pkg::V_OP_ERASE_64K;
      8'hA2: data_o = spr_pkg::V_ZERO;
      8'hA3: data_o = spr_pkg::V_ZERO;
      // every other location is reserved
      default: data_o = spr_pkg::V_RSVD;
    endcase
  end

endmodule
`default_nettype wire

// ==== logic/spr_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module spr_top (
  input wire logic CLOCK_I, // 20 MHz system clock
  input wire logic SYS_RST_I, // async reset, active high
  input wire logic CS_N_I, // serial chip select, active low
  input wire logic SCK_I, // serial clock from host
  input wire logic DI_I, // serial data in
  output logic DO_O, // serial data out, registered
  output logic DO_OE_O, // data out enable, high while driving
  output logic ADDR_FAULT_O // upper address bits seen nonzero
);

  typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP} spr_state_t;

  spr_pkg::spr_pins_t pin_s1_r;
  spr_pkg::spr_pins_t pin_s2_r;
  logic sck_d_r;
  logic cs_idle;
  logic sck_rise;
  logic sck_fall;
  spr_state_t state_r;
  logic [5:0] clk_cnt_r;
  logic [7:0] in_sh_r;
  logic [7:0] in_nxt;
  logic [7:0] addr_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] out_sh_r;
  logic dout_r;
  logic oe_r;
  logic fault_r;
  logic load_byte;
  logic [7:0] rom_data;

  // two-flop synchroniser; stage one feeds only stage two
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_s1_r <= '{cs_n: 1'b1, sck: 1'b0, di: 1'b0};
      pin_s2_r <= '{cs_n: 1'b1, sck: 1'b0, di: 1'b0};
    end else begin
      pin_s1_r <= '{cs_n: CS_N_I, sck: SCK_I, di: DI_I};
      pin_s2_r <= pin_s1_r;
    end
  end

  // previous serial clock level for edge detection
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= pin_s2_r.sck;
    end
  end

  // edges are seen late by the sync delay, so sck must stay well under clk/4
  assign cs_idle = pin_s2_r.cs_n;
  assign sck_rise = pin_s2_r.sck & ~sck_d_r & ~cs_idle;
  assign sck_fall = ~pin_s2_r.sck & sck_d_r & ~cs_idle;
  assign in_nxt = {in_sh_r[6:0], pin_s2_r.di};

  // rising-edge clock count, saturates once the header is through
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      clk_cnt_r <= 6'h00;
    end else if (cs_idle) begin
      clk_cnt_r <= 6'h00;
    end else if (sck_rise && clk_cnt_r != spr_pkg::HDR_END) begin
      clk_cnt_r <= clk_cnt_r + 6'h01;
    end
  end

  // input shift register, sampled on sck rising edges
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      in_sh_r <= 8'h00;
    end else if (cs_idle) begin
      in_sh_r <= 8'h00;
    end else if (sck_rise) begin
      in_sh_r <= in_nxt;
    end
  end

  // frame sequencing; deselect always returns to opcode phase
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_r <= ST_CMD;
    end else if (cs_idle) begin
      state_r <= ST_CMD;
    end else if (sck_rise) begin
      case (state_r)
        ST_CMD: begin
          if (clk_cnt_r == spr_pkg::CMD_END - 6'h01) begin
            // other opcodes belong to other blocks; stay silent
            state_r <= (in_nxt == spr_pkg::CMD_READ_PARAM) ? ST_ADDR : ST_SKIP;
          end
        end
        ST_ADDR: begin
          if (clk_cnt_r == spr_pkg::ADDR_END - 6'h01) begin
            state_r <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (clk_cnt_r == spr_pkg::HDR_END - 6'h01) begin
            state_r <= ST_DATA;
          end
        end
        ST_DATA: state_r <= ST_DATA;
        ST_SKIP: state_r <= ST_SKIP;
        default: state_r <= ST_SKIP;
      endcase
    end
  end

  // a new byte is fetched on the first fall of every eight
  assign load_byte = sck_fall && state_r == ST_DATA && bit_cnt_r == 3'h0;

  // byte address: only the low eight address bits are kept
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      addr_r <= 8'h00;
    end else if (sck_rise && state_r == ST_ADDR) begin
      addr_r <= in_nxt;
    end else if (load_byte) begin
      addr_r <= addr_r + 8'h01;
    end
  end

  // flags a host that sent nonzero upper address bits
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fault_r <= 1'b0;
    end else if (cs_idle) begin
      fault_r <= 1'b0;
    end else if (sck_rise && state_r == ST_ADDR && clk_cnt_r < spr_pkg::ADDR_HI_END &&
                 pin_s2_r.di) begin
      fault_r <= 1'b1;
    end
  end

  // bit position within the output byte
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      bit_cnt_r <= 3'h0;
    end else if (cs_idle) begin
      bit_cnt_r <= 3'h0;
    end else if (sck_fall && state_r == ST_DATA) begin
      bit_cnt_r <= (bit_cnt_r == spr_pkg::BYTE_LAST_BIT) ? 3'h0 : bit_cnt_r + 3'h1;
    end
  end

  // msb-first output shifter, updated on sck falling edges
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      out_sh_r <= 7'h00;
      dout_r <= 1'b0;
    end else if (load_byte) begin
      dout_r <= rom_data[7];
      out_sh_r <= rom_data[6:0];
    end else if (sck_fall && state_r == ST_DATA) begin
      dout_r <= out_sh_r[6];
      out_sh_r <= {out_sh_r[5:0], 1'b0};
    end
  end

  // drive only from the first data fall until deselect
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      oe_r <= 1'b0;
    end else if (cs_idle) begin
      oe_r <= 1'b0;
    end else if (load_byte) begin
      oe_r <= 1'b1;
    end
  end

  // constant table lookup
  spr_rom u_rom (
    .addr_i(addr_r),
    .data_o(rom_data)
  );

  assign DO_O = dout_r;
  assign DO_OE_O = oe_r;
  assign ADDR_FAULT_O = fault_r;

  // checks on table contents
  sig_bytes_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h03 |-> rom_data == 8'h50)
    else $error("signature top byte wrong");
  hdr_count_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h06 |-> rom_data == 8'h00)
    else $error("header count wrong");
  tbl_len_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h0B |-> rom_data == 8'h09)
    else $error("table length wrong");
  tbl_ptr_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h0C |-> rom_data == 8'h80)
    else $error("table pointer wrong");
  rsvd_ff_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    (addr_r > spr_pkg::A_HDR_LAST && addr_r < spr_pkg::A_BASIC) ||
    addr_r > spr_pkg::A_BASIC_LAST |-> rom_data == 8'hFF)
    else $error("reserved byte not FF");
  read_caps_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h82 |-> rom_data == 8'hF1)
    else $error("read caps wrong");
  erase4_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'hA3 |-> rom_data == 8'h00)
    else $error("erase type four not zero");
  // further fixed bytes, one probe per rule, so a bad edit of a probed byte is caught here
  sig_low_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h00 |-> rom_data == 8'h53)
    else $error("signature low byte wrong");
  sig_mid_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h01 |-> rom_data == 8'h46)
    else $error("signature second byte wrong");
  sig_third_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h02 |-> rom_data == 8'h44)
    else $error("signature third byte wrong");
  rev_major_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h05 |-> rom_data == 8'h01)
    else $error("major revision wrong");
  tbl_ident_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h08 |-> rom_data == 8'h00)
    else $error("table ident wrong");
  tbl_rev_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h0A |-> rom_data == 8'h01)
    else $error("table revision wrong");
  erase_caps_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h80 |-> rom_data == 8'hE5)
    else $error("erase caps wrong");
  dens_low_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h84 |-> rom_data == 8'hFF)
    else $error("density low byte wrong");
  dens_top_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h87 |-> rom_data == 8'h07)
    else $error("density top byte wrong");
  quad_io_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h88 |-> rom_data == 8'h44)
    else $error("quad io settings wrong");
  quad_out_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h8B |-> rom_data == 8'h6B)
    else $error("quad output opcode wrong");
  dual_out_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h8D |-> rom_data == 8'h3B)
    else $error("dual output opcode wrong");
  dual_io_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h8E |-> rom_data == 8'h80)
    else $error("dual io settings wrong");
  wide_caps_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h90 |-> rom_data == 8'hFE)
    else $error("wide read caps wrong");
  wide_none_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h97 |-> rom_data == 8'h00)
    else $error("two-line opcode not zero");
  cmd_mode_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h9B |-> rom_data == 8'hEB)
    else $error("command mode opcode wrong");
  erase_one_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h9C |-> rom_data == 8'h0C)
    else $error("erase type one size wrong");
  erase_two_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'h9F |-> rom_data == 8'h52)
    else $error("erase type two opcode wrong");
  erase_three_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    addr_r == 8'hA1 |-> rom_data == 8'hD8)
    else $error("erase type three opcode wrong");
  rom_const_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    $stable(addr_r) |-> $stable(rom_data))
    else $error("table byte changed");

  // output sequencing
  sequence fetch_s;
    load_byte;
  endsequence
  sequence next_byte_s;
    ##1 (addr_r == $past(addr_r) + 8'h01) && DO_OE_O;
  endsequence

  data_start_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    $rose(state_r == ST_DATA) |-> clk_cnt_r == spr_pkg::HDR_END && !DO_OE_O)
    else $error("data phase entered at wrong clock");
  addr_step_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    fetch_s |-> next_byte_s)
    else $error("byte address did not advance");
  msb_first_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    fetch_s |=> DO_O == $past(rom_data[7]))
    else $error("first bit not msb");
  oe_idle_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_r != ST_DATA |-> ##1 !DO_OE_O || state_r == ST_DATA)
    else $error("driving outside data phase");

  // framing checks; the fault flag must follow one frame only, never carry over
  sequence upper_one_s;
    sck_rise && state_r == ST_ADDR && clk_cnt_r < spr_pkg::ADDR_HI_END && pin_s2_r.di;
  endsequence
  low_addr_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    $rose(state_r == ST_DUMMY) |-> addr_r == $past(in_nxt))
    else $error("start address not low byte");
  fault_set_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    upper_one_s |=> ADDR_FAULT_O)
    else $error("upper address one not flagged");
  fault_clear_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    cs_idle |=> !ADDR_FAULT_O)
    else $error("fault flag kept after deselect");
  oe_off_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    cs_idle |=> !DO_OE_O)
    else $error("driving after deselect");
  skip_quiet_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    state_r == ST_SKIP |-> !DO_OE_O)
    else $error("driving on foreign opcode");
  bit_step_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    sck_fall && state_r == ST_DATA && bit_cnt_r != 3'h0 |=> DO_O == $past(out_sh_r[6]))
    else $error("output bit order wrong");
  data_hold_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    !sck_fall |=> $stable(DO_O))
    else $error("output bit moved without a fall");
  cnt_sat_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    clk_cnt_r <= spr_pkg::HDR_END)
    else $error("clock count ran past header");
  addr_wrap_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    load_byte && addr_r == 8'hFF |=> addr_r == 8'h00)
    else $error("address did not wrap");

endmodule
`default_nettype wire

// ==== verif/spr_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module spr_host_model #(
  parameter int PHASE = 5 // clocks per serial clock phase
) (
  input wire logic clk_i, // system clock
  output logic cs_n_o, // chip select, active low
  output logic sck_o, // serial clock, idles low
  output logic di_o, // serial data to device
  input wire logic do_i, // serial data from device
  input wire logic do_oe_i, // device drives data
  output logic [7:0] byte_o, // last whole byte received
  output logic byte_vld_o, // one-cycle pulse per byte read wholly with enable high
  output logic [15:0] oe_miss_o // bits sampled with enable low
);
  logic in_frame;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    di_o = 1'b0;
    byte_o = 8'h00;
    byte_vld_o = 1'b0;
    oe_miss_o = 16'h0000;
    in_frame = 1'b0;
  end
  // released data line toggles so a stale value is never read as valid
  always @(posedge clk_i) begin
    if (!in_frame) di_o <= ~di_o;
    if (byte_vld_o) byte_vld_o <= 1'b0;
  end
  task automatic send_bit(input logic b);
    sck_o <= 1'b0;
    di_o <= b;
    repeat (PHASE) @(posedge clk_i);
    sck_o <= 1'b1;
    repeat (PHASE) @(posedge clk_i);
  endtask
  // sample on the falling clock edge, clear of the device's updates
  task automatic recv_bit(output logic b, output logic ok);
    sck_o <= 1'b0;
    repeat (PHASE - 1) @(posedge clk_i);
    @(negedge clk_i);
    b = do_i;
    ok = (do_oe_i === 1'b1);
    if (!ok) oe_miss_o = oe_miss_o + 16'h0001;
    @(posedge clk_i);
    sck_o <= 1'b1;
    repeat (PHASE) @(posedge clk_i);
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input logic [9:0] n);
    logic [39:0] hdr;
    logic [7:0] rx;
    logic ok;
    logic all_ok;
    hdr = {op, addr, 8'h00};
    @(posedge clk_i);
    in_frame <= 1'b1;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (PHASE) @(posedge clk_i);
    for (int i = 39; i >= 0; i--) send_bit(hdr[i]);
    for (int k = 0; k < n; k++) begin
      all_ok = 1'b1;
      for (int j = 7; j >= 0; j--) begin
        recv_bit(rx[j], ok);
        all_ok = all_ok & ok;
      end
      if (all_ok) begin
        byte_o <= rx;
        byte_vld_o <= 1'b1;
      end
    end
    cs_n_o <= 1'b1;
    @(posedge clk_i);
    sck_o <= 1'b0;
    in_frame <= 1'b0;
    repeat (PHASE) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk;
  logic rst;
  logic cs_n;
  logic sck;
  logic di;
  logic dout;
  logic dout_oe;
  logic addr_fault;
  logic [7:0] rx_byte;
  logic rx_vld;
  logic [15:0] oe_miss;
  logic [7:0] exp_q[$];
  logic fault_seen;
  logic [31:0] rng;
  int n_mismatch;
  int checks;
  int cycles;
  spr_top i_spr_top (.CLOCK_I(clk), .SYS_RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck),
    .DI_I(di), .DO_O(dout), .DO_OE_O(dout_oe), .ADDR_FAULT_O(addr_fault));
  spr_host_model i_spr_host_model (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .di_o(di),
    .do_i(dout), .do_oe_i(dout_oe), .byte_o(rx_byte), .byte_vld_o(rx_vld), .oe_miss_o(oe_miss));
  initial clk = 1'b0;
  always #25 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // expected table, worked out independently of the design
  function automatic logic [7:0] ref_byte(input logic [7:0] a);
    logic [7:0] r;
    case (a)
      8'h00: r = 8'h53;
      8'h01: r = 8'h46;
      8'h02: r = 8'h44;
      8'h03: r = 8'h50;
      8'h05, 8'h0A: r = 8'h01;
      8'h04, 8'h06, 8'h08, 8'h09: r = 8'h00;
      8'h0B: r = 8'h09;
      8'h0C: r = 8'h80;
      8'h0D, 8'h0E: r = 8'h00;
      8'h80: r = 8'hE5;
      8'h81, 8'h9D: r = 8'h20;
      8'h82: r = 8'hF1;
      8'h87: r = 8'h07;
      8'h88: r = 8'h44;
      8'h89, 8'h9B: r = 8'hEB;
      8'h8A, 8'h8C, 8'h9A: r = 8'h08;
      8'h8B: r = 8'h6B;
      8'h8D: r = 8'h3B;
      8'h8E: r = 8'h80;
      8'h8F: r = 8'hBB;
      8'h90: r = 8'hFE;
      8'h96, 8'h97, 8'hA2, 8'hA3: r = 8'h00;
      8'h9C: r = 8'h0C;
      8'h9E: r = 8'h0F;
      8'h9F: r = 8'h52;
      8'hA0: r = 8'h10;
      8'hA1: r = 8'hD8;
      default: r = 8'hFF;
    endcase
    return r;
  endfunction
  // watcher: each received byte against the oldest note
  always @(posedge clk) begin
    if (rx_vld === 1'b1) begin
      if (exp_q.size() == 0) begin
        // no note pending: 0100h can never match a received byte
        check({8'h00, rx_byte}, 16'h0100);
      end else begin
        check({8'h00, rx_byte}, {8'h00, exp_q.pop_front()});
      end
    end
  end
  always @(negedge clk) if (addr_fault === 1'b1) fault_seen = 1'b1;
  // hang guard, well above the planned run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic run(input logic [7:0] op, input logic [23:0] addr, input logic [9:0] n,
      input logic flt);
    logic [15:0] miss0;
    miss0 = oe_miss;
    if (op == 8'h5A) for (int k = 0; k < n; k++) exp_q.push_back(ref_byte(addr[7:0] + k[7:0]));
    fault_seen = 1'b0;
    i_spr_host_model.frame(op, addr, n);
    @(negedge clk); // clear of the edge that updates the flag
    check({15'h0000, fault_seen}, {15'h0000, flt});
    check({15'h0000, addr_fault}, 16'h0000);
    check(oe_miss - miss0, (op == 8'h5A) ? 16'h0000 : {3'h0, n, 3'h0});
  endtask
  initial begin
    rst = 1'b1;
    rng = 32'h5D8578F7;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // whole table plus wrap past the last byte
    run(8'h5A, 24'h000000, 10'd258, 1'b0);
    $display("test table end");
    // random starts and lengths, back to back
    repeat (6) begin
      rng = xs(rng);
      run(8'h5A, {16'h0000, rng[7:0]}, {7'h00, rng[10:8]} + 10'd1, 1'b0);
    end
    $display("test random end");
    // nonzero upper address: flagged, low byte still selects
    run(8'h5A, 24'h010088, 10'd2, 1'b1);
    rng = xs(rng);
    run(8'h5A, {1'b0, rng[14:0], 8'hFE}, 10'd3, |rng[14:0]);
    $display("test upper end");
    // any other opcode leaves the output undriven
    repeat (3) begin
      rng = xs(rng);
      run((rng[7:0] == 8'h5A) ? 8'h5B : rng[7:0], 24'h000000, 10'd1, 1'b0);
    end
    $display("test opcode end");
    check(16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
